// ---- ldc_defs.svh ----
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define LDC_ADDR_CONTROL   12'h000
`define LDC_ADDR_CODE      12'h004
`define LDC_ADDR_STATUS    12'h008

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LDC_BIT_ENABLE     7
`define LDC_BIT_PINOE      5
`define LDC_BIT_PSS_HI     3
`define LDC_BIT_PSS_LO     2
`define LDC_BIT_NSS        0
`define LDC_CODE_HI        4

// ----------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------
`define LDC_CONTROL_MASK   8'had
`define LDC_CODE_MASK      8'h1f
`define LDC_CONTROL_RESET  8'h00
`define LDC_CODE_RESET     8'h00

`endif

// ---- ldc_pkg.sv ----
package ldc_pkg;

    // Positive reference choice
    typedef enum logic [1:0] {
        LDC_POS_SUPPLY   = 2'h0,
        LDC_POS_EXTPIN   = 2'h1,
        LDC_POS_FIXEDREF = 2'h2,
        LDC_POS_RESERVED = 2'h3
    } ldc_pos_ref_t;

    // Controls handed to the analog ladder and pin switch
    typedef struct packed {
        logic         converterEnable;
        logic         levelPinOutputEnable;
        ldc_pos_ref_t positiveReferenceSelect;
        logic         negativeReferenceSelect;
        logic [4:0]   outputLevelCode;
    } ldc_analog_ctl_t;

    // Pin override controls for the level output pin
    typedef struct packed {
        logic digitalDriverOff;
        logic inputDetectorOff;
        logic weakPullupOff;
        logic currentDriveOff;
    } ldc_pin_ovr_t;

endpackage

// ---- ldc_apb_slave.sv ----
`include "ldc_defs.svh"

// APB slave for the converter registers; single wait-free access
module ldc_apb_slave (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [7:0]  controlRd,
    input  wire logic [7:0]  codeRd,
    input  wire logic [7:0]  statusRd,
    output logic             wrControl,
    output logic             wrCode,
    output logic [7:0]       wrData,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    logic        access;
    logic        mapped;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign access    = psel & penable;
    assign mapped    = (paddr == `LDC_ADDR_CONTROL) | (paddr == `LDC_ADDR_CODE)
                     | (paddr == `LDC_ADDR_STATUS);
    assign wrControl = access & pwrite & pstrb[0] & (paddr == `LDC_ADDR_CONTROL);
    assign wrCode    = access & pwrite & pstrb[0] & (paddr == `LDC_ADDR_CODE);
    assign wrData    = pwdata[7:0];
    assign pready    = 1'b1;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;

    // Read data prepared during setup, valid through access
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel & ~penable) begin
            unique case (paddr)
                `LDC_ADDR_CONTROL: prdata_nxt = {24'h000000, controlRd};
                `LDC_ADDR_CODE:    prdata_nxt = {24'h000000, codeRd};
                `LDC_ADDR_STATUS:  prdata_nxt = {24'h000000, statusRd};
                default:           prdata_nxt = 32'h00000000;
            endcase
            pslverr_nxt = ~mapped;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

endmodule

// ---- ladder_dac_control.sv ----
`include "ldc_defs.svh"

module ladder_dac_control (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    levelPinIn,
    output ldc_pkg::ldc_analog_ctl_t     analogCtl,
    output ldc_pkg::ldc_pin_ovr_t        pinOverride,
    output logic                         levelPinDigitalIn
);

    logic       wrControl;
    logic       wrCode;
    logic [7:0] wrData;
    logic [7:0] control_r;
    logic [7:0] control_nxt;
    logic [7:0] code_r;
    logic [7:0] code_nxt;
    logic       pinSync0_r;
    logic       pinSync1_r;
    logic       pinDigIn_r;
    logic       pinDigIn_nxt;
    logic [7:0] statusRd;
    ldc_pkg::ldc_analog_ctl_t analog_r;
    ldc_pkg::ldc_analog_ctl_t analog_nxt;
    ldc_pkg::ldc_pin_ovr_t    pinOvr_r;
    ldc_pkg::ldc_pin_ovr_t    pinOvr_nxt;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    ldc_apb_slave u_apb (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pstrb     (pstrb),
        .controlRd (control_r),
        .codeRd    (code_r),
        .statusRd  (statusRd),
        .wrControl (wrControl),
        .wrCode    (wrCode),
        .wrData    (wrData),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr)
    );

    // Status shows the enable, pin and reference controls actually driven to the ladder; level code not included
    assign statusRd = {analog_r.converterEnable, 1'b0, analog_r.levelPinOutputEnable, 1'b0,
                       analog_r.positiveReferenceSelect, 1'b0, analog_r.negativeReferenceSelect};

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Writes masked to implemented bits; no sleep or wake input touches them
    always_comb begin
        control_nxt = control_r;
        code_nxt    = code_r;
        if (wrControl) begin
            control_nxt = wrData & `LDC_CONTROL_MASK;
        end
        if (wrCode) begin
            code_nxt = wrData & `LDC_CODE_MASK;
        end
    end

    // Any reset clears enable, pin routing and level code
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            control_r <= `LDC_CONTROL_RESET;
            code_r    <= `LDC_CODE_RESET;
        end else begin
            control_r <= control_nxt;
            code_r    <= code_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Analog controls
    // ----------------------------------------------------------------
    // Decode stored bits into ladder and pin controls
    always_comb begin
        analog_nxt.converterEnable         = control_r[`LDC_BIT_ENABLE];
        analog_nxt.levelPinOutputEnable    = control_r[`LDC_BIT_PINOE];
        analog_nxt.positiveReferenceSelect =
            ldc_pkg::ldc_pos_ref_t'(control_r[`LDC_BIT_PSS_HI:`LDC_BIT_PSS_LO]);
        analog_nxt.negativeReferenceSelect = control_r[`LDC_BIT_NSS];
        analog_nxt.outputLevelCode         = code_r[`LDC_CODE_HI:0];
        pinOvr_nxt.digitalDriverOff        = control_r[`LDC_BIT_PINOE];
        pinOvr_nxt.inputDetectorOff        = control_r[`LDC_BIT_PINOE];
        pinOvr_nxt.weakPullupOff           = control_r[`LDC_BIT_PINOE];
        pinOvr_nxt.currentDriveOff         = control_r[`LDC_BIT_PINOE];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            analog_r <= '0;
            pinOvr_r <= '0;
        end else begin
            analog_r <= analog_nxt;
            pinOvr_r <= pinOvr_nxt;
        end
    end

    assign analogCtl   = analog_r;
    assign pinOverride = pinOvr_r;

    // ----------------------------------------------------------------
    // Pin digital read
    // ----------------------------------------------------------------
    // Two-stage synchroniser on the pin input
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinSync0_r <= 1'b0;
            pinSync1_r <= 1'b0;
        end else begin
            pinSync0_r <= levelPinIn;
            pinSync1_r <= pinSync0_r;
        end
    end

    // Read forced low while the pin carries the converter voltage
    always_comb begin
        pinDigIn_nxt = pinSync1_r & ~control_r[`LDC_BIT_PINOE];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinDigIn_r <= 1'b0;
        end else begin
            pinDigIn_r <= pinDigIn_nxt;
        end
    end

    assign levelPinDigitalIn = pinDigIn_r;

endmodule

// ---- ldc_chk_sva.sv ----
// ----
// Register to ladder control checks
// ----
module ldc_chk_sva (
    input wire logic                     sys_clk,
    input wire logic                     resetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic                     pslverr,
    input wire ldc_pkg::ldc_analog_ctl_t analogCtl,
    input wire ldc_pkg::ldc_pin_ovr_t    pinOverride,
    input wire logic                     levelPinDigitalIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrCtl;
    logic wrCode;
    // Completed low-byte writes
    assign wrCtl  = psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
    assign wrCode = psel && penable && pwrite && pstrb[0] && paddr == 12'h004;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_EN: assert property (wrCtl |-> ##2 analogCtl.converterEnable == $past(pwdata[7], 2))
        else $error("enable not taken");
    AST_OE: assert property (wrCtl |-> ##2 analogCtl.levelPinOutputEnable == $past(pwdata[5], 2))
        else $error("pin enable not taken");
    AST_PSS: assert property (wrCtl |-> ##2 analogCtl.positiveReferenceSelect == $past(pwdata[3:2], 2))
        else $error("positive select not taken");
    AST_NSS: assert property (wrCtl |-> ##2 analogCtl.negativeReferenceSelect == $past(pwdata[0], 2))
        else $error("negative select not taken");
    AST_CODE: assert property (wrCode |-> ##2 analogCtl.outputLevelCode == $past(pwdata[4:0], 2))
        else $error("level code not taken");
    AST_OVR: assert property (pinOverride == {4{analogCtl.levelPinOutputEnable}})
        else $error("pin override wrong");
    AST_PINZ: assert property (analogCtl.levelPinOutputEnable |-> !levelPinDigitalIn)
        else $error("routed pin reads high");
    AST_RST: assert property ($rose(resetn) |-> analogCtl == '0 && pinOverride == '0)
        else $error("reset left controls set");
    AST_HOLD: assert property (!(wrCtl || wrCode) |-> ##2 $stable(analogCtl))
        else $error("controls moved without write");
    cover property (wrCtl ##2 analogCtl.levelPinOutputEnable);
    cover property (wrCode && pwdata[4:0] == 5'h1f);
    cover property (psel && penable && pslverr);
endmodule

bind ladder_dac_control ldc_chk_sva chk (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pslverr, .analogCtl, .pinOverride, .levelPinDigitalIn);

// ---- ldc_ladder_model.sv ----
// ----
// Ladder and pin switch model
// ----
module ldc_ladder_model (
    input wire logic                     sys_clk,
    input wire ldc_pkg::ldc_analog_ctl_t analogCtl,
    input wire logic                     extLevel,
    output logic                         levelPinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] tap;
    logic [2:0] refs;
    logic       flip = 1'b0;
    // Tap and ladder ends in use
    assign tap  = analogCtl.converterEnable ? analogCtl.outputLevelCode : 5'h00;
    assign refs = {analogCtl.positiveReferenceSelect, analogCtl.negativeReferenceSelect};
    // Routed pin is analog: digital view changes every cycle
    always @(posedge sys_clk) flip <= ~flip;
    assign levelPinIn = analogCtl.levelPinOutputEnable ? flip : extLevel;
endmodule

// ---- ladder_dac_control_tb.sv ----
module ladder_dac_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     sys_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [11:0]              paddr = 12'h000;
    logic [31:0]              pwdata = 32'h00000000;
    logic [3:0]               pstrb = 4'h0;
    logic                     extLevel = 1'b0;
    logic [31:0]              prdata;
    logic                     pready, pslverr, levelPinIn, levelPinDigitalIn;
    ldc_pkg::ldc_analog_ctl_t analogCtl;
    ldc_pkg::ldc_pin_ovr_t    pinOverride;
    int                       fails = 0;
    int                       n_tests = 0;
    int                       cyc = 0;
    logic [31:0]              rd;
    logic                     err;

    ladder_dac_control dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .levelPinIn, .analogCtl, .pinOverride, .levelPinDigitalIn);
    ldc_ladder_model model (.sys_clk, .analogCtl, .extLevel, .levelPinIn);

    // Clock and hang guard
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic test_reset();
        apb(1'b1, 12'h000, 32'h000000a5, 4'hf);
        apb(1'b1, 12'h004, 32'h00000015, 4'hf);
        @(posedge sys_clk);
        chk(32'(analogCtl), 32'({1'b1, 1'b1, 2'b01, 1'b1, 5'h15}));
        do_reset();
        chk(32'(analogCtl), 32'h0);
        chk(32'(pinOverride), 32'h0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk(rd, 32'h0);
        $display("test_reset done");
    endtask

    task automatic test_ctrl();
        logic [7:0] v [3] = '{8'hd2, 8'hf7, 8'h6b};
        foreach (v[i]) begin
            apb(1'b1, 12'h000, {24'hffffff, v[i]}, 4'h1);
            repeat (2) @(posedge sys_clk);
            chk(32'(analogCtl[9:5]), 32'({v[i][7], v[i][5], v[i][3:2], v[i][0]}));
            chk(32'(pinOverride), 32'({4{v[i][5]}}));
            apb(1'b0, 12'h000, 32'h0, 4'h0);
            chk(rd, 32'(v[i] & 8'had));
            apb(1'b0, 12'h008, 32'h0, 4'h0);
            chk(rd, 32'(v[i] & 8'had));
        end
        $display("test_ctrl done");
    endtask

    task automatic test_code();
        logic [7:0] c [3] = '{8'h00, 8'he1, 8'hff};
        foreach (c[i]) begin
            apb(1'b1, 12'h004, {24'h0, c[i]}, 4'h1);
            repeat (2) @(posedge sys_clk);
            chk(32'(analogCtl.outputLevelCode), 32'(c[i][4:0]));
            apb(1'b0, 12'h004, 32'h0, 4'h0);
            chk(rd, 32'(c[i] & 8'h1f));
        end
        apb(1'b1, 12'h004, 32'h0000000a, 4'he);
        apb(1'b1, 12'h010, 32'h000000ff, 4'hf);
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk(rd, 32'h1f);
        $display("test_code done");
    endtask

    task automatic test_pin();
        apb(1'b1, 12'h000, 32'h00000080, 4'h1);
        extLevel <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(32'(levelPinDigitalIn), 32'h1);
        apb(1'b1, 12'h000, 32'h000000a0, 4'h1);
        repeat (2) @(posedge sys_clk);
        repeat (4) begin
            @(posedge sys_clk);
            chk(32'(levelPinDigitalIn), 32'h0);
        end
        repeat (50) @(posedge sys_clk);
        chk(32'(analogCtl[9:8]), 32'h3);
        $display("test_pin done");
    endtask

    // Main sequence
    initial begin
        do_reset();
        test_reset();
        test_ctrl();
        test_code();
        test_pin();
        print_verdict();
    end
endmodule
